// file: bench/oscillator_select_control_tb_top.sv
// Self-checking bench for the oscillator select control block.
// Assumes osc_pkg and osc_ctrl are compiled first; short failure limits are used.
`timescale 1ns/1ps
module oscillator_select_control_tb_top;
  import osc_pkg::*;
  logic              sys_clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [15:0]       wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o, rdat;
  logic              xtl_off_opt, sysclk_monitor_i, watchdog_osc_i, mon_run, wd_run;
  logic [1:0]        drive_opt, drive_mode;
  logic              rc_en, fast, xtl_en, pins_ovr, filt_en, wdt_en, pri_ev, wdt_ev;
  logic [NUM_SRC-1:0] gate;
  logic [7:0]        cur, v;
  int                bad_count, tests_run, cycles, pri_cnt, wdt_cnt, s;

  osc_ctrl #(.PRI_LIMIT(40), .WDT_LIMIT(30)) u_osc_ctrl (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .crystal_off_at_reset_option_i(xtl_off_opt),
    .crystal_drive_mode_option_i(drive_opt), .sysclk_monitor_i(sysclk_monitor_i),
    .watchdog_osc_i(watchdog_osc_i), .internal_rc_enable_o(rc_en), .internal_precision_osc_fast_o(fast),
    .crystal_osc_enable_o(xtl_en), .crystal_pins_override_o(pins_ovr), .crystal_drive_mode_o(drive_mode),
    .crystal_filter_enable_o(filt_en), .watchdog_osc_enable_o(wdt_en), .sysclk_source_gate_o(gate),
    .primary_fail_event_o(pri_ev), .watchdog_fail_event_o(wdt_ev));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Oscillator activity, event counting and the hang limit.
  always @(posedge sys_clk_i) begin
    if (mon_run) sysclk_monitor_i <= ~sysclk_monitor_i;
    if (wd_run) watchdog_osc_i <= ~watchdog_osc_i;
    if (pri_ev === 1'b1) pri_cnt++;
    if (wdt_ev === 1'b1) wdt_cnt++;
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One classic Wishbone cycle; the request is held until ack is sampled.
  task automatic xfer(input logic we, input logic [15:0] adr, input logic [7:0] d);
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0000_00, d};
    wb_sel_i <= 4'hf;
    do begin
      @(posedge sys_clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  function automatic logic [NUM_SRC-1:0] gate_of(input logic [2:0] sel);
    gate_of = (sel < 3'h5) ? NUM_SRC'(1) << sel : '0;
  endfunction

  // Unlock with an unmapped access between the keys, write, then try a locked write.
  task automatic wr3(input logic [7:0] val);
    xfer(1'b1, CTL_ADDR, UNLOCK_FIRST);
    xfer(1'b0, 16'h0100, 8'h00);
    check("unmapped read", rdat, 32'h0000_0000);
    xfer(1'b1, CTL_ADDR, UNLOCK_SECOND);
    xfer(1'b1, CTL_ADDR, val);
    cur = val;
    xfer(1'b1, CTL_ADDR, 8'h5a);
    xfer(1'b0, CTL_ADDR, 8'h00);
    check("control register", rdat, {24'h0000_00, cur});
  endtask

  task automatic cfg(input logic [7:0] val);
    if (val[2:0] != cur[2:0]) wr3(cur & 8'he7);
    wr3(val);
  endtask

  task automatic chk_out();
    repeat (6) @(posedge sys_clk_i);
    check("rc enable", rc_en, cur[7]);
    check("crystal enable", xtl_en, cur[6]);
    check("pin override", pins_ovr, cur[6]);
    check("wdt enable", wdt_en, cur[5]);
    check("gate", gate, gate_of(cur[2:0]));
    check("fast", fast, cur[2:0] != 3'h1);
    check("filter", filt_en, 1'b0);
    check("drive mode", drive_mode, drive_opt);
  endtask

  task automatic do_reset(input logic opt);
    xtl_off_opt <= opt;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    cur = {1'b1, ~opt, 6'h20};
    xfer(1'b0, CTL_ADDR, 8'h00);
    check("reset register", rdat, {24'h0000_00, cur});
    chk_out();
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {sys_rst_i, xtl_off_opt, sysclk_monitor_i, watchdog_osc_i} = 4'b1000;
    {mon_run, wd_run} = 2'b11;
    {bad_count, tests_run, cycles, pri_cnt, wdt_cnt} = '0;
    drive_opt = 2'h2;
    void'($urandom(32558));
    do_reset(1'b1);
    do_reset(1'b0);
    // Out of order keys and a broken sequence leave the register alone.
    xfer(1'b1, CTL_ADDR, UNLOCK_SECOND);
    xfer(1'b1, CTL_ADDR, 8'h41);
    xfer(1'b1, CTL_ADDR, UNLOCK_FIRST);
    xfer(1'b1, CTL_ADDR, 8'h42);
    xfer(1'b1, CTL_ADDR, UNLOCK_SECOND);
    xfer(1'b1, CTL_ADDR, 8'h43);
    xfer(1'b0, CTL_ADDR, 8'h00);
    check("ignored writes", rdat, {24'h0000_00, cur});
    for (s = 0; s < 5; s++) begin
      cfg({5'b1110_0, s[2:0]});
      chk_out();
    end
    // Crystal stays on so it needs no settling wait and is never cut while selected.
    repeat (20) begin
      s = $urandom % 5;
      v = 8'($urandom);
      v[2:0] = s[2:0];
      v[6] = 1'b1;
      if (s == 3) v[5] = 1'b1;
      if (s < 2) v[7] = 1'b1;
      drive_opt <= 2'($urandom);
      cfg(v);
      chk_out();
    end
    check("no false primary event", pri_cnt, 0);
    check("no false wdt event", wdt_cnt, 0);
    cfg(8'he0);
    mon_run = 1'b0;
    repeat (100) @(posedge sys_clk_i);
    check("primary off no event", pri_cnt, 0);
    cfg(8'hf0);
    mon_run = 1'b0;
    repeat (100) @(posedge sys_clk_i);
    check("primary event", pri_cnt, 1);
    xfer(1'b0, CTL_ADDR, 8'h00);
    check("recovery select", rdat, 32'h0000_00f3);
    cur = 8'hf3;
    chk_out();
    mon_run = 1'b1;
    cfg(8'he8);
    wd_run = 1'b0;
    repeat (100) @(posedge sys_clk_i);
    check("wdt event", wdt_cnt, 1);
    tally_and_finish();
  end
endmodule

// file: core/osc_clk_switch.sv
// Glitch-free source gate switch for the system clock mux.
// Assumes the select input comes from a register in the same clock domain.
`timescale 1ns/1ps
module osc_clk_switch
  import osc_pkg::*;
#(
  parameter int unsigned GAP = SWITCH_GAP_CYCLES
) (
  // Clock and reset.
  input  wire logic               sys_clk_i,
  input  wire logic               sys_rst_i,
  // Select and gates.
  input  wire logic [2:0]         sel_i,
  output logic      [NUM_SRC-1:0] gate_o
);
  logic [2:0] cur_reg;
  logic [3:0] gap_reg;

  // A change drops every gate, waits, then opens only the new source.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur_reg <= SRC_IPO_FAST;
      gap_reg <= 4'h0;
      gate_o  <= 5'h01;
    end else if (sel_i != cur_reg) begin
      cur_reg <= sel_i;
      gap_reg <= 4'(GAP);
      gate_o  <= '0;
    end else if (gap_reg != 4'h0) begin
      gap_reg <= gap_reg - 4'h1;
    end else if (cur_reg < 3'(NUM_SRC)) begin
      gate_o <= 5'(5'h01 << cur_reg);
    end else begin
      gate_o <= '0;
    end
  end

  property p_gate_break;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (sel_i != cur_reg) |=> (gate_o == '0) ##1 (gate_o == '0);
  endproperty
  a_gate_break: assert property (p_gate_break) else $error("gate not broken on switch");

  property p_gate_onehot;
    @(posedge sys_clk_i) disable iff (sys_rst_i) $onehot0(gate_o);
  endproperty
  a_gate_onehot: assert property (p_gate_onehot) else $error("two gates open");
endmodule

// file: core/osc_ctrl.sv
// Oscillator select control: locked control register, failure detection, source gating.
// Assumes synchronous inputs, oscillator activity sampled as levels, Wishbone master on sys_clk_i.
// Contract
// - Unlock needs a write of E7 then a write of 18 to the control register.
// - The next write updates the register and locks it again at once.
// - Bit 7 turns the internal precision oscillator on or off.
// - Bit 6 turns the crystal on and overrides the two crystal pins in the same cycle.
// - Bit 5 turns the watchdog oscillator on or off.
// - Bit 4 enables primary failure detection and recovery; cleared means neither.
// - Bit 3 enables watchdog oscillator failure detection.
// - Select code 000 runs the system clock from the internal oscillator, fast.
// - Select code 001 runs it from the internal oscillator, slow.
// - Select code 010 runs it from the crystal or external RC oscillator.
// - Select code 011 runs it from the watchdog oscillator.
// - Select code 100 runs it from the external clock input pin.
// - A nonvolatile option decides whether the crystal runs after reset; it is off during reset.
// - Crystal drive mode comes from nonvolatile option bits.
// - The crystal input clock filter is off by default.
// - Out of order writes are ignored; unlock writes need not be adjacent.
// - Primary clock below about 1 kHz raises an event and, with bit 5 set, switches to watchdog.
// - Watchdog failure declared after 8004 cycles without a watchdog edge.
`timescale 1ns/1ps
module osc_ctrl
  import osc_pkg::*;
#(
  parameter int unsigned PRI_LIMIT = PRI_FAIL_CYCLES,
  parameter int unsigned WDT_LIMIT = WDT_FAIL_CYCLES
) (
  // Clock and reset.
  input  wire logic               sys_clk_i,
  input  wire logic               sys_rst_i,
  // Wishbone slave.
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [15:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Nonvolatile options.
  input  wire logic               crystal_off_at_reset_option_i,
  input  wire logic [1:0]         crystal_drive_mode_option_i,
  // Sampled oscillator activity.
  input  wire logic               sysclk_monitor_i,
  input  wire logic               watchdog_osc_i,
  // Oscillator controls.
  output logic                    internal_rc_enable_o,
  output logic                    internal_precision_osc_fast_o,
  output logic                    crystal_osc_enable_o,
  output logic                    crystal_pins_override_o,
  output logic      [1:0]         crystal_drive_mode_o,
  output logic                    crystal_filter_enable_o,
  output logic                    watchdog_osc_enable_o,
  output logic      [NUM_SRC-1:0] sysclk_source_gate_o,
  // Failure events.
  output logic                    primary_fail_event_o,
  output logic                    watchdog_fail_event_o
);
  logic [7:0]  oscillator_control_reg;
  osc_lock_t   lock_reg;
  logic        strap_done_reg;
  logic        mon_prev_reg;
  logic        wdt_prev_reg;
  logic [15:0] pri_cnt_reg;
  logic [15:0] wdt_cnt_reg;
  logic        wdt_failed_reg;
  logic        wr_ctl;
  logic        rd_ctl;
  logic [7:0]  wr_byte;
  logic        pri_watch;
  logic        wdt_watch;
  logic        pri_trip;
  logic        wdt_trip;
  logic [2:0]  src_sel;

  function automatic logic ctl_hit(input logic [15:0] adr);
    return adr[15:2] == CTL_ADDR[15:2];
  endfunction

  // Bus decode; a write needs the low byte lane.
  assign wr_byte = wb_dat_i[7:0];
  assign wr_ctl  = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0] & ctl_hit(wb_adr_i);
  assign rd_ctl  = ctl_hit(wb_adr_i);
  assign src_sel = oscillator_control_reg[2:0];

  // Ack one cycle after the strobe, dropped the next; unmapped reads give zero.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_ctl ? {24'h00_0000, oscillator_control_reg} : 32'h0000_0000;
    end
  end

  // Unlock sequence; other registers may be touched in between.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_reg <= OSC_LOCKED;
    end else if (wr_ctl) begin
      case (lock_reg)
        OSC_LOCKED: begin
          lock_reg <= (wr_byte == UNLOCK_FIRST) ? OSC_GOT_FIRST : OSC_LOCKED;
        end
        OSC_GOT_FIRST: begin
          if (wr_byte == UNLOCK_SECOND) begin
            lock_reg <= OSC_UNLOCKED;
          end else if (wr_byte == UNLOCK_FIRST) begin
            lock_reg <= OSC_GOT_FIRST;
          end else begin
            lock_reg <= OSC_LOCKED;
          end
        end
        OSC_UNLOCKED: begin
          lock_reg <= OSC_LOCKED;
        end
        default: begin
          lock_reg <= OSC_LOCKED;
        end
      endcase
    end
  end

  // Failure watch conditions.
  assign pri_watch = oscillator_control_reg[BIT_POF_EN] & ~wdt_failed_reg & (src_sel != SRC_WDT);
  assign wdt_watch = oscillator_control_reg[BIT_WOF_EN] & oscillator_control_reg[BIT_WDT_EN]
                     & (src_sel != SRC_WDT) & ~wdt_failed_reg;
  assign pri_trip  = pri_watch & (pri_cnt_reg == 16'(PRI_LIMIT - 1));
  assign wdt_trip  = wdt_watch & (wdt_cnt_reg == 16'(WDT_LIMIT - 1));

  // Control register: strap load after reset, unlocked write, failure recovery.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oscillator_control_reg <= CTL_RESET;
      strap_done_reg         <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
      if (!strap_done_reg) begin
        oscillator_control_reg[BIT_XTL_EN] <= ~crystal_off_at_reset_option_i;
      end else if (wr_ctl && lock_reg == OSC_UNLOCKED) begin
        oscillator_control_reg <= wr_byte;
      end else if (pri_trip && oscillator_control_reg[BIT_WDT_EN]) begin
        oscillator_control_reg[2:0] <= SRC_WDT;
      end
    end
  end

  // Primary clock watch: cycles since the last monitor edge.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mon_prev_reg <= 1'b0;
      pri_cnt_reg  <= 16'h0000;
    end else begin
      mon_prev_reg <= sysclk_monitor_i;
      if (!pri_watch || (sysclk_monitor_i != mon_prev_reg) || pri_trip) begin
        pri_cnt_reg <= 16'h0000;
      end else begin
        pri_cnt_reg <= pri_cnt_reg + 16'h0001;
      end
    end
  end

  // Watchdog oscillator watch; a failure also ends primary detection.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wdt_prev_reg   <= 1'b0;
      wdt_cnt_reg    <= 16'h0000;
      wdt_failed_reg <= 1'b0;
    end else begin
      wdt_prev_reg <= watchdog_osc_i;
      if (!wdt_watch || (watchdog_osc_i != wdt_prev_reg) || wdt_trip) begin
        wdt_cnt_reg <= 16'h0000;
      end else begin
        wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
      end
      if (wdt_trip) begin
        wdt_failed_reg <= 1'b1;
      end
    end
  end

  // Event pulses.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      primary_fail_event_o  <= 1'b0;
      watchdog_fail_event_o <= 1'b0;
    end else begin
      primary_fail_event_o  <= pri_trip;
      watchdog_fail_event_o <= wdt_trip;
    end
  end

  // Oscillator enables and options.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      internal_rc_enable_o          <= 1'b1;
      internal_precision_osc_fast_o <= 1'b1;
      crystal_osc_enable_o          <= 1'b0;
      crystal_pins_override_o       <= 1'b0;
      crystal_drive_mode_o          <= 2'h0;
      crystal_filter_enable_o       <= 1'b0;
      watchdog_osc_enable_o         <= 1'b1;
    end else begin
      internal_rc_enable_o          <= oscillator_control_reg[BIT_INT_EN];
      internal_precision_osc_fast_o <= (src_sel != SRC_IPO_SLOW);
      crystal_osc_enable_o          <= oscillator_control_reg[BIT_XTL_EN];
      crystal_pins_override_o       <= oscillator_control_reg[BIT_XTL_EN];
      crystal_drive_mode_o          <= crystal_drive_mode_option_i;
      crystal_filter_enable_o       <= 1'b0;
      watchdog_osc_enable_o         <= oscillator_control_reg[BIT_WDT_EN];
    end
  end

  // Source gating; codes 010, 011 and 100 open crystal, watchdog and pin gates.
  osc_clk_switch u_switch (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .sel_i     (src_sel),
    .gate_o    (sysclk_source_gate_o)
  );

  sequence s_first;
    wr_ctl && lock_reg == OSC_GOT_FIRST && wr_byte == UNLOCK_SECOND;
  endsequence

  sequence s_config_write;
    wr_ctl && lock_reg == OSC_UNLOCKED;
  endsequence

  property p_unlock;
    @(posedge sys_clk_i) disable iff (sys_rst_i) s_first |=> lock_reg == OSC_UNLOCKED;
  endproperty
  a_unlock: assert property (p_unlock) else $error("second key did not unlock");

  property p_relock;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_config_write |=> lock_reg == OSC_LOCKED && oscillator_control_reg == $past(wr_byte);
  endproperty
  a_relock: assert property (p_relock) else $error("config write not taken or not relocked");

  property p_ignore;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      strap_done_reg && !pri_trip && !(wr_ctl && lock_reg == OSC_UNLOCKED)
      |=> $stable(oscillator_control_reg);
  endproperty
  a_ignore: assert property (p_ignore) else $error("locked register changed");

  property p_enables;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      ##1 internal_rc_enable_o == $past(oscillator_control_reg[BIT_INT_EN])
      && watchdog_osc_enable_o == $past(oscillator_control_reg[BIT_WDT_EN])
      && crystal_pins_override_o == crystal_osc_enable_o;
  endproperty
  a_enables: assert property (p_enables) else $error("enable outputs wrong");

  property p_pri_fail;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      pri_trip && oscillator_control_reg[BIT_WDT_EN] && !wr_ctl
      |=> primary_fail_event_o && src_sel == SRC_WDT;
  endproperty
  a_pri_fail: assert property (p_pri_fail) else $error("primary failure not handled");

  property p_no_detect;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      !oscillator_control_reg[BIT_POF_EN] |=> !primary_fail_event_o;
  endproperty
  a_no_detect: assert property (p_no_detect) else $error("event with detection off");

  property p_wdt_fail;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      wdt_watch && wdt_cnt_reg == 16'(WDT_LIMIT - 2) && watchdog_osc_i == wdt_prev_reg
      ##1 watchdog_osc_i == wdt_prev_reg && wdt_watch |=> watchdog_fail_event_o;
  endproperty
  a_wdt_fail: assert property (p_wdt_fail) else $error("watchdog failure missed");

  property p_filter_off;
    @(posedge sys_clk_i) disable iff (sys_rst_i) !crystal_filter_enable_o;
  endproperty
  a_filter_off: assert property (p_filter_off) else $error("crystal filter on");

  property p_ack;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");

  property p_crystal;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      1'b1 |=> crystal_osc_enable_o == $past(oscillator_control_reg[BIT_XTL_EN])
      && crystal_pins_override_o == $past(oscillator_control_reg[BIT_XTL_EN]);
  endproperty
  a_crystal: assert property (p_crystal) else $error("crystal enable or pin override wrong");

  property p_wdt_enable;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      1'b1 |=> watchdog_osc_enable_o == $past(oscillator_control_reg[BIT_WDT_EN]);
  endproperty
  a_wdt_enable: assert property (p_wdt_enable) else $error("watchdog enable wrong");

  property p_fast;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      1'b1 |=> internal_precision_osc_fast_o == ($past(src_sel) != SRC_IPO_SLOW);
  endproperty
  a_fast: assert property (p_fast) else $error("internal rate wrong");

  property p_drive;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      1'b1 |=> crystal_drive_mode_o == $past(crystal_drive_mode_option_i);
  endproperty
  a_drive: assert property (p_drive) else $error("drive mode not from option");

  property p_strap;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      !strap_done_reg |=> oscillator_control_reg[BIT_XTL_EN] == !$past(crystal_off_at_reset_option_i);
  endproperty
  a_strap: assert property (p_strap) else $error("crystal reset option not loaded");

  property p_pri_quiet;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      !pri_watch |=> pri_cnt_reg == 16'h0000;
  endproperty
  a_pri_quiet: assert property (p_pri_quiet) else $error("primary watch counts while off");

  sequence s_wdt_declared;
    watchdog_fail_event_o && wdt_failed_reg ##1 !watchdog_fail_event_o;
  endsequence

  property p_wdt_once;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      wdt_trip |=> s_wdt_declared;
  endproperty
  a_wdt_once: assert property (p_wdt_once) else $error("watchdog failure not declared once");

  property p_unmapped;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o && !ctl_hit(wb_adr_i) |=> wb_ack_o && wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered wrong");

  property p_read;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o && ctl_hit(wb_adr_i)
      |=> wb_dat_o == {24'h00_0000, $past(oscillator_control_reg)};
  endproperty
  a_read: assert property (p_read) else $error("control register read wrong");
endmodule

// file: core/osc_pkg.sv
// Constants for the oscillator select control block.
// Assumes a 20 MHz system clock and a classic Wishbone register port.
package osc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Primary failure threshold: one period of the 1 kHz limit.
  localparam int unsigned PRI_FAIL_TIME_NS = 1000000;
  localparam int unsigned PRI_FAIL_CYCLES = PRI_FAIL_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WDT_FAIL_CYCLES = 8004;
  localparam int unsigned SWITCH_GAP_CYCLES = 2;
  // Register index as printed; byte address is four times it.
  localparam logic [15:0] CTL_INDEX = 16'h0f86;
  localparam logic [15:0] CTL_ADDR = 16'h3e18;
  localparam logic [7:0] UNLOCK_FIRST = 8'he7;
  localparam logic [7:0] UNLOCK_SECOND = 8'h18;
  localparam int unsigned BIT_INT_EN = 7;
  localparam int unsigned BIT_XTL_EN = 6;
  localparam int unsigned BIT_WDT_EN = 5;
  localparam int unsigned BIT_POF_EN = 4;
  localparam int unsigned BIT_WOF_EN = 3;
  localparam logic [2:0] SRC_IPO_FAST = 3'h0;
  localparam logic [2:0] SRC_IPO_SLOW = 3'h1;
  localparam logic [2:0] SRC_CRYSTAL = 3'h2;
  localparam logic [2:0] SRC_WDT = 3'h3;
  localparam logic [2:0] SRC_EXT_PIN = 3'h4;
  localparam int unsigned NUM_SRC = 5;
  // Reset value with the crystal enable cleared; the strap sets it later.
  localparam logic [7:0] CTL_RESET = 8'ha0;
  typedef enum logic [1:0] {
    OSC_LOCKED,
    OSC_GOT_FIRST,
    OSC_UNLOCKED
  } osc_lock_t;
endpackage
